/* File: src/smcg_defs.svh */
// offsets, field positions, reset values and codes of the sleep clock gating block
`ifndef SMCG_DEFS_SVH
`define SMCG_DEFS_SVH
// register byte offsets
`define SMCG_OFF_RUN_CFG    12'h060
`define SMCG_OFF_RUN_GATE   12'h100
`define SMCG_OFF_SLEEP_GATE 12'h110
`define SMCG_OFF_DEEP_GATE  12'h120
`define SMCG_OFF_IRQ_STAT   12'h130
`define SMCG_OFF_IRQ_EN     12'h134
`define SMCG_OFF_IRQ_CLR    12'h138
// gating register fields
`define SMCG_BIT_ADC        16
`define SMCG_BIT_WDT        3
`define SMCG_RATE_LSB       8
`define SMCG_RATE_MSB       9
`define SMCG_GATE_RESET     32'h0000_0040
`define SMCG_GATE_RW_MASK   32'h0001_0308
// run clock configuration fields
`define SMCG_BIT_AUTO_GATE  27
`define SMCG_CFG_RESET      32'h0000_0000
`define SMCG_CFG_RW_MASK    32'h0800_0000
// interrupt event bits
`define SMCG_IRQ_W          2
`define SMCG_EV_ADC         0
`define SMCG_EV_WDT         1
// sample rate codes
`define SMCG_RATE_125K      2'h0
`define SMCG_RATE_250K      2'h1
`define SMCG_RATE_500K      2'h2
`endif

/* File: src/smcg_pkg.sv */
// types shared by the sleep clock gating block
package smcg_pkg;
  // power state as presented by the power manager
  typedef enum logic [1:0] {
    SMCG_PWR_RUN   = 2'h0,
    SMCG_PWR_SLEEP = 2'h1,
    SMCG_PWR_DEEP  = 2'h2
  } smcg_pwr_t;
  // peripheral unit selector for access checks
  typedef enum logic {
    SMCG_UNIT_ADC = 1'h0,
    SMCG_UNIT_WDT = 1'h1
  } smcg_unit_t;
endpackage

/* File: src/smcg_sleep_gate.sv */
// sleep-mode clock gating control with apb registers and fault reporting
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "smcg_defs.svh"

// Behaviour
// [R1] each gate bit drives one unit clock enable
// [R2] access to gated-off unit answers bus fault
// [R3] gates reset cleared; register resets to 0x40
// [R4] run, sleep, deep registers chosen by state
// [R5] sleep gating applies only when select set
// [R6] bit 16 gates converter clock in sleep
// [R7] bit 3 gates watchdog clock in sleep
// [R8] bits 9:8 hold converter sample rate field
// [R9] rate codes 2,1,0: 500k,250k,125k
// [R10] software keeps rate within supported maximum
// [R11] reserved bits read zero, writes ignored
// [R12] select clear: run register used in sleep
module smcg_sleep_gate #(
  parameter int         ADDR_W   = 12,            // apb address width
  parameter logic [1:0] MAX_RATE = `SMCG_RATE_500K // highest supported rate code
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // power state from the power manager
  input  wire smcg_pkg::smcg_pwr_t pwr_state,
  // peripheral access check
  input  wire logic              per_req,
  input  wire smcg_pkg::smcg_unit_t per_sel,
  output logic                   per_done,
  output logic                   per_fault,
  // unit clock enables and converter rate
  output logic                   adc_clk_en,
  output logic                   wdt_clk_en,
  output logic [2:0]             adc_rate_sel,
  // interrupt
  output logic                   irq
);

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  // offsets reach 0x138, rate codes above 2 have no decode
  if (ADDR_W < 9 || ADDR_W > 32)
  begin : g_chk_addr
    $error("smcg: ADDR_W out of range");
  end
  if (MAX_RATE > `SMCG_RATE_500K)
  begin : g_chk_rate
    $error("smcg: MAX_RATE above highest decoded rate");
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [31:0]            run_gate_reg;    // run mode gating
  logic [31:0]            run_gate_next;
  logic [31:0]            sleep_gate_reg;  // sleep mode gating
  logic [31:0]            sleep_gate_next;
  logic [31:0]            deep_gate_reg;   // deep sleep gating
  logic [31:0]            deep_gate_next;
  logic [31:0]            run_cfg_reg;     // run clock configuration
  logic [31:0]            run_cfg_next;
  logic [`SMCG_IRQ_W-1:0] irq_stat_reg;    // sticky events
  logic [`SMCG_IRQ_W-1:0] irq_stat_next;
  logic [`SMCG_IRQ_W-1:0] irq_en_reg;      // event enables
  logic [`SMCG_IRQ_W-1:0] irq_en_next;
  logic [31:0]            prdata_reg;
  logic [31:0]            prdata_next;
  logic                   pready_reg;
  logic                   pready_next;
  logic                   pslverr_reg;
  logic                   pslverr_next;
  logic                   per_done_reg;
  logic                   per_done_next;
  logic                   per_fault_reg;
  logic                   per_fault_next;
  logic                   adc_en_reg;
  logic                   adc_en_next;
  logic                   wdt_en_reg;
  logic                   wdt_en_next;
  logic [2:0]             rate_reg;
  logic [2:0]             rate_next;
  logic                   irq_reg;
  logic                   irq_next;
  logic [31:0]            gate_eff;        // gating in force now
  logic                   setup_ph;        // apb setup cycle
  logic                   wr_commit;       // write takes effect
  logic                   addr_hit;        // address is mapped
  logic [11:0]            offs;            // low address bits
  logic [`SMCG_IRQ_W-1:0] ev_set;          // events this cycle
  logic [`SMCG_IRQ_W-1:0] ev_clr;          // software clears
  logic [1:0]             rate_code;       // clamped rate code

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  // pready is raised for exactly the first access cycle, so every
  // transfer completes with one access phase and no wait states
  assign setup_ph  = psel && !penable;
  assign wr_commit = psel && penable && pready_reg && pwrite;
  assign offs      = 12'(paddr);
  always_comb
  begin
    // word-aligned hits only; misaligned offsets are refused
    unique case (offs)
      `SMCG_OFF_RUN_CFG, `SMCG_OFF_RUN_GATE, `SMCG_OFF_SLEEP_GATE,
      `SMCG_OFF_DEEP_GATE, `SMCG_OFF_IRQ_STAT, `SMCG_OFF_IRQ_EN,
      `SMCG_OFF_IRQ_CLR: addr_hit = (ADDR_W <= 12) || (paddr >> 12) == '0;
      default:           addr_hit = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // gating selection by power state
  // ------------------------------------------------------------
  // sleep and deep sleep gating only count when the select bit is
  // set; otherwise the run register stays in force
  always_comb
  begin
    gate_eff = run_gate_reg;                                   // R4 R12
    if (run_cfg_reg[`SMCG_BIT_AUTO_GATE])                      // R5
    begin
      unique case (pwr_state)
        smcg_pkg::SMCG_PWR_SLEEP: gate_eff = sleep_gate_reg;   // R4
        smcg_pkg::SMCG_PWR_DEEP:  gate_eff = deep_gate_reg;    // R4
        default:                  gate_eff = run_gate_reg;
      endcase
    end
    // with the select clear, gate_eff keeps the run register  // R12
  end

  // ------------------------------------------------------------
  // register file next values
  // ------------------------------------------------------------
  // write masks keep read-only and reserved bits at reset value
  always_comb
  begin
    run_gate_next   = run_gate_reg;
    sleep_gate_next = sleep_gate_reg;
    deep_gate_next  = deep_gate_reg;
    run_cfg_next    = run_cfg_reg;
    irq_en_next     = irq_en_reg;
    ev_clr          = '0;
    if (wr_commit)
    begin
      unique case (offs)
        `SMCG_OFF_RUN_GATE:
          run_gate_next = (pwdata & `SMCG_GATE_RW_MASK)
                        | (`SMCG_GATE_RESET & ~`SMCG_GATE_RW_MASK);
        `SMCG_OFF_SLEEP_GATE:
          sleep_gate_next = (pwdata & `SMCG_GATE_RW_MASK)     // R6 R7 R8
                          | (`SMCG_GATE_RESET & ~`SMCG_GATE_RW_MASK); // R11
        `SMCG_OFF_DEEP_GATE:
          deep_gate_next = (pwdata & `SMCG_GATE_RW_MASK)
                         | (`SMCG_GATE_RESET & ~`SMCG_GATE_RW_MASK);
        `SMCG_OFF_RUN_CFG:
          run_cfg_next = pwdata & `SMCG_CFG_RW_MASK;
        `SMCG_OFF_IRQ_EN:
          irq_en_next = pwdata[`SMCG_IRQ_W-1:0];
        `SMCG_OFF_IRQ_CLR:
          ev_clr = pwdata[`SMCG_IRQ_W-1:0];
        default:
          run_cfg_next = run_cfg_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // apb answer next values
  // ------------------------------------------------------------
  // read data and error are prepared in the setup cycle so that
  // the bus outputs come straight from flip-flops
  always_comb
  begin
    prdata_next  = 32'h0000_0000;
    pready_next  = setup_ph;
    pslverr_next = setup_ph && !addr_hit;
    if (setup_ph && !pwrite)
    begin
      unique case (offs)
        `SMCG_OFF_RUN_GATE:   prdata_next = run_gate_reg;
        `SMCG_OFF_SLEEP_GATE: prdata_next = sleep_gate_reg;    // R11
        `SMCG_OFF_DEEP_GATE:  prdata_next = deep_gate_reg;
        `SMCG_OFF_RUN_CFG:    prdata_next = run_cfg_reg;
        `SMCG_OFF_IRQ_STAT:   prdata_next = 32'(irq_stat_reg);
        `SMCG_OFF_IRQ_EN:     prdata_next = 32'(irq_en_reg);
        default:              prdata_next = 32'h0000_0000;  // clear is write-only
      endcase
    end
  end

  // ------------------------------------------------------------
  // peripheral access check
  // ------------------------------------------------------------
  // a request to an unclocked unit is answered with a fault; the
  // unit never sees it since its clock is stopped
  always_comb
  begin
    ev_set         = '0;
    per_done_next  = 1'b0;
    per_fault_next = 1'b0;
    if (per_req)
    begin
      unique case (per_sel)
        smcg_pkg::SMCG_UNIT_ADC:
        begin
          per_fault_next        = !gate_eff[`SMCG_BIT_ADC];    // R2 R6
          ev_set[`SMCG_EV_ADC]  = !gate_eff[`SMCG_BIT_ADC];
        end
        smcg_pkg::SMCG_UNIT_WDT:
        begin
          per_fault_next        = !gate_eff[`SMCG_BIT_WDT];    // R2 R7
          ev_set[`SMCG_EV_WDT]  = !gate_eff[`SMCG_BIT_WDT];
        end
      endcase
      per_done_next = !per_fault_next;
    end
  end

  // ------------------------------------------------------------
  // clock enables, rate decode and interrupt next values
  // ------------------------------------------------------------
  // an out-of-range code is clamped so the converter is never
  // driven faster than it can sample; code 3 falls to MAX_RATE
  always_comb
  begin
    adc_en_next = gate_eff[`SMCG_BIT_ADC];                     // R1 R6
    wdt_en_next = gate_eff[`SMCG_BIT_WDT];                     // R1 R7
    rate_code   = gate_eff[`SMCG_RATE_MSB:`SMCG_RATE_LSB];     // R8
    if (rate_code > MAX_RATE)                                  // R10
      rate_code = MAX_RATE;
    unique case (rate_code)                                    // R9
      `SMCG_RATE_500K: rate_next = 3'h4;
      `SMCG_RATE_250K: rate_next = 3'h2;
      default:         rate_next = 3'h1;
    endcase
    // a new event wins over a clear in the same cycle
    irq_stat_next = (irq_stat_reg & ~ev_clr) | ev_set;
    irq_next      = |(irq_stat_next & irq_en_next);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      run_gate_reg   <= `SMCG_GATE_RESET;
      sleep_gate_reg <= `SMCG_GATE_RESET;                      // R3
      deep_gate_reg  <= `SMCG_GATE_RESET;
      run_cfg_reg    <= `SMCG_CFG_RESET;
      irq_stat_reg   <= '0;
      irq_en_reg     <= '0;
      prdata_reg     <= 32'h0000_0000;
      pready_reg     <= 1'b0;
      pslverr_reg    <= 1'b0;
      per_done_reg   <= 1'b0;
      per_fault_reg  <= 1'b0;
      adc_en_reg     <= 1'b0;                                  // R3
      wdt_en_reg     <= 1'b0;                                  // R3
      rate_reg       <= 3'h1;
      irq_reg        <= 1'b0;
    end
    else
    begin
      run_gate_reg   <= run_gate_next;
      sleep_gate_reg <= sleep_gate_next;
      deep_gate_reg  <= deep_gate_next;
      run_cfg_reg    <= run_cfg_next;
      irq_stat_reg   <= irq_stat_next;
      irq_en_reg     <= irq_en_next;
      prdata_reg     <= prdata_next;
      pready_reg     <= pready_next;
      pslverr_reg    <= pslverr_next;
      per_done_reg   <= per_done_next;
      per_fault_reg  <= per_fault_next;
      adc_en_reg     <= adc_en_next;
      wdt_en_reg     <= wdt_en_next;
      rate_reg       <= rate_next;
      irq_reg        <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign per_done     = per_done_reg;
  assign per_fault    = per_fault_reg;
  assign adc_clk_en   = adc_en_reg;
  assign wdt_clk_en   = wdt_en_reg;
  assign adc_rate_sel = rate_reg;
  assign irq          = irq_reg;

endmodule

/* File: dv/smcg_sleep_gate_properties.sv */
// concurrent checks on the ports of the sleep clock gating block
`timescale 1ns/1ps
`include "smcg_defs.svh"
module smcg_sleep_gate_properties #(
  parameter int         ADDR_W   = 12,
  parameter logic [1:0] MAX_RATE = 2'h2
) (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 sys_rst,
  // apb slave side
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [ADDR_W-1:0]    paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // power state and unit access
  input wire smcg_pkg::smcg_pwr_t  pwr_state,
  input wire logic                 per_req,
  input wire smcg_pkg::smcg_unit_t per_sel,
  input wire logic                 per_done,
  input wire logic                 per_fault,
  // enables, rate and interrupt
  input wire logic                 adc_clk_en,
  input wire logic                 wdt_clk_en,
  input wire logic [2:0]           adc_rate_sel,
  input wire logic                 irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ----
  // helper: anything that may legally move a gate
  // ----
  smcg_pkg::smcg_pwr_t pwr_q_reg; // state seen one cycle ago
  logic                cause;     // write, state change or reset
  assign cause = (psel & penable & pwrite) | (pwr_q_reg != pwr_state) | sys_rst;
  // register the state so a change shows as a one-cycle cause
  always_ff @(posedge clock)
    pwr_q_reg <= pwr_state;
  // ----
  // assertions
  // ----
  a_gate_has_cause: assert property (($changed(adc_clk_en) || $changed(wdt_clk_en))
    |-> $past(cause) || $past(cause, 2) || $past(cause, 3)) else $error("gate moved alone");
  // the answer and the enable beside it both come from the gating of the request cycle
  a_fault_when_gated: assert property ((per_req && per_sel == smcg_pkg::SMCG_UNIT_ADC)
    |=> per_fault == !adc_clk_en && per_done == adc_clk_en) else $error("converter answer wrong");
  a_done_when_clocked: assert property ((per_req && per_sel == smcg_pkg::SMCG_UNIT_WDT)
    |=> per_done == wdt_clk_en && per_fault == !wdt_clk_en) else $error("watchdog answer wrong");
  a_one_answer: assert property (per_req |=> per_done != per_fault)
    else $error("access not answered once");
  a_no_spurious_answer: assert property (!per_req |=> !per_done && !per_fault)
    else $error("answer without request");
  a_rate_onehot: assert property ($onehot(adc_rate_sel))
    else $error("rate select not one-hot");
  a_reset_gates_off: assert property (disable iff (1'b0) sys_rst |=> !adc_clk_en
    && !wdt_clk_en && adc_rate_sel == 3'h1) else $error("reset left a gate on");
  a_sleep_reserved_read: assert property ((psel && penable && pready && !pwrite
    && paddr == `SMCG_OFF_SLEEP_GATE) |-> (prdata & 32'hFFFE_FCB7) == 32'h0 && prdata[6])
    else $error("reserved bits wrong");
endmodule

bind smcg_sleep_gate smcg_sleep_gate_properties #(
  .ADDR_W(ADDR_W),
  .MAX_RATE(MAX_RATE)
) i_props (
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwr_state(pwr_state), .per_req(per_req), .per_sel(per_sel), .per_done(per_done),
  .per_fault(per_fault), .adc_clk_en(adc_clk_en), .wdt_clk_en(wdt_clk_en),
  .adc_rate_sel(adc_rate_sel), .irq(irq)
);

/* File: dv/smcg_sleep_gate_tb_top.sv */
// self-checking testbench of the sleep clock gating block
`timescale 1ns/1ps
`include "smcg_defs.svh"
module smcg_sleep_gate_tb_top;
  logic                 clock = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [11:0]          paddr = 12'h0;
  logic [31:0]          pwdata = 32'h0;
  logic                 per_req = 1'b0;
  smcg_pkg::smcg_pwr_t  pwr_state = smcg_pkg::SMCG_PWR_RUN;
  smcg_pkg::smcg_unit_t per_sel = smcg_pkg::SMCG_UNIT_ADC;
  logic [31:0]          prdata;
  logic                 pready, pslverr, per_done, per_fault, adc_clk_en, wdt_clk_en, irq;
  logic [2:0]           adc_rate_sel;
  int                   miscompares = 0;
  int                   checked = 0;
  logic [33:0]          rq[$]; // apb notes: write flag, error, read data
  logic [1:0]           pq[$]; // unit notes: fault, done
  logic [33:0]          e;
  logic [31:0]          r;

  smcg_sleep_gate i_dut (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwr_state(pwr_state), .per_req(per_req), .per_sel(per_sel), .per_done(per_done),
    .per_fault(per_fault), .adc_clk_en(adc_clk_en), .wdt_clk_en(wdt_clk_en),
    .adc_rate_sel(adc_rate_sel), .irq(irq)
  );

  always #4 clock = ~clock;

  // ----
  // comparison and bus tasks
  // ----
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // one apb transfer; for a read d is the expected data
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic er);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    rq.push_back({w, er, d});
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one unit access; gaps between calls keep each request a single pulse
  task automatic preq(input smcg_pkg::smcg_unit_t u, input logic [1:0] x);
    @(posedge clock);
    per_req <= 1'b1;
    per_sel <= u;
    pq.push_back(x);
    @(posedge clock);
    per_req <= 1'b0;
  endtask
  // levels settle a few cycles after their cause
  task automatic lvl(input logic a, input logic w, input logic i);
    repeat (3) @(posedge clock);
    cmp({29'h0, adc_clk_en, wdt_clk_en, irq}, {29'h0, a, w, i});
  endtask
  task automatic give_verdict;
    if (rq.size() != 0 || pq.size() != 0) miscompares++;
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----
  // watcher: takes the oldest note whenever a result appears
  // ----
  always @(posedge clock)
  begin
    if (psel && penable && pready === 1'b1 && rq.size() > 0)
    begin
      e = rq.pop_front();
      cmp({31'h0, pslverr}, {31'h0, e[32]});
      if (!e[33]) cmp(prdata, e[31:0]);
    end
    if (per_done === 1'b1 || per_fault === 1'b1)
      cmp({30'h0, per_fault, per_done}, {30'h0, pq.pop_front()});
  end

  // hang guard, far beyond the roughly 180 cycles the tests take
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    r = $urandom(32'hCA02);
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    apb(0, `SMCG_OFF_SLEEP_GATE, `SMCG_GATE_RESET, 0);
    apb(0, `SMCG_OFF_RUN_GATE, `SMCG_GATE_RESET, 0);
    apb(0, `SMCG_OFF_RUN_CFG, 32'h0, 0);
    apb(0, 12'h070, 32'h0, 1);
    lvl(0, 0, 0);
    apb(1, `SMCG_OFF_RUN_GATE, 32'h0001_0008, 0);
    lvl(1, 1, 0);
    pwr_state <= smcg_pkg::SMCG_PWR_SLEEP;
    lvl(1, 1, 0);
    apb(1, `SMCG_OFF_RUN_CFG, 32'h0800_0000, 0);
    lvl(0, 0, 0);
    preq(smcg_pkg::SMCG_UNIT_ADC, 2'h2);
    preq(smcg_pkg::SMCG_UNIT_WDT, 2'h2);
    apb(1, `SMCG_OFF_SLEEP_GATE, 32'h0000_0008, 0);
    lvl(0, 1, 0);
    preq(smcg_pkg::SMCG_UNIT_WDT, 2'h1);
    preq(smcg_pkg::SMCG_UNIT_ADC, 2'h2);
    pwr_state <= smcg_pkg::SMCG_PWR_DEEP;
    lvl(0, 0, 0);
    // deep sleep gating is its own register, not a copy of the sleep one
    apb(1, `SMCG_OFF_DEEP_GATE, 32'h0000_0008, 0);
    lvl(0, 1, 0);
    apb(0, `SMCG_OFF_DEEP_GATE, 32'h0000_0048, 0);
    apb(0, 12'h112, 32'h0, 1);
    pwr_state <= smcg_pkg::SMCG_PWR_SLEEP;
    for (int c = 0; c < 3; c++)
    begin
      apb(1, `SMCG_OFF_SLEEP_GATE, 32'h0001_0000 | (32'(c) << 8), 0);
      apb(0, `SMCG_OFF_SLEEP_GATE, 32'h0001_0040 | (32'(c) << 8), 0);
      lvl(1, 0, 0);
      cmp({29'h0, adc_rate_sel}, 32'h1 << c);
    end
    // random writes keep the rate code legal for the device
    repeat (4)
    begin
      r = $urandom() & 32'hFFFF_FDFF;
      apb(1, `SMCG_OFF_SLEEP_GATE, r, 0);
      apb(0, `SMCG_OFF_SLEEP_GATE, (r & `SMCG_GATE_RW_MASK) | `SMCG_GATE_RESET, 0);
    end
    apb(1, `SMCG_OFF_SLEEP_GATE, 32'h0, 0);
    apb(1, `SMCG_OFF_IRQ_CLR, 32'h3, 0);
    apb(1, `SMCG_OFF_IRQ_EN, 32'h0, 0);
    preq(smcg_pkg::SMCG_UNIT_ADC, 2'h2);
    lvl(0, 0, 0);
    apb(0, `SMCG_OFF_IRQ_STAT, 32'h1, 0);
    apb(1, `SMCG_OFF_IRQ_EN, 32'h3, 0);
    lvl(0, 0, 1);
    apb(1, `SMCG_OFF_IRQ_CLR, 32'h1, 0);
    lvl(0, 0, 0);
    apb(0, `SMCG_OFF_IRQ_STAT, 32'h0, 0);
    apb(0, `SMCG_OFF_IRQ_CLR, 32'h0, 0);
    pwr_state <= smcg_pkg::SMCG_PWR_RUN;
    lvl(1, 1, 0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    lvl(0, 0, 0);
    apb(0, `SMCG_OFF_RUN_GATE, `SMCG_GATE_RESET, 0);
    repeat (3) @(posedge clock);
    give_verdict();
  end
endmodule
